// ### hdl/fpl_fault_protection.sv
// fault protection and latching for both channels of the switch
// assumes comparator and sensor inputs are synchronous to clk_sys and that register
// reads and delatch requests arrive as one-cycle pulses from the serial port logic
`timescale 1ns/1ns

// What this block does
// - per-channel overtemperature turns channel off, sets its flag, pulls fault low
// - after overtemperature, fault pin releases only on a turn-on while both channels are cool
// - overtemperature while off also pulls fault low until cool and turned on
// - auto-retry turns a channel back on once it has cooled
// - overtemperature flag clears on fault register read when cool and fault high
// - overcurrent turns channel off, sets its flag, pulls fault low
// - trip on active threshold crossed or window width exceeded
// - while a window is active, its channel's sensing is blanked and sync held high
// - load type 0 picks the lighting profile, 1 the motor profile
// - lighting: high, middle, low thresholds over two timed windows of selectable width
// - lighting profile re-armed at each turn-on, only at first turn-on in switch mode
// - motor: one window opened by current above low threshold, width limited
// - with auto-retry, overcurrent latches only after all retries are used
// - in switch mode the counter accumulates on-time only and trips past width
// - delatch clears the counter; lighting also clears it at each auto-retry
// - motor clears the counter at turn-off after an on-period without overcurrent
// - in switch mode modulation never clears the counter; for motor only delatch does
// - short-circuit at turn-on shuts off, pulls fault low, sets its flag
// - enabled overvoltage turns both off and pulls fault low until below hysteresis
// - status register read after overvoltage ends clears its flag
// - with overvoltage disabled only the warning flag is set
module fpl_fault_protection
  import fpl_pkg::*;
#(
  parameter int NUM_CHAN = 2,
  parameter logic [3:0] RETRY_MAX = 4'hf
)
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  // per-channel control and configuration
  input wire fpl_chan_cfg_s [NUM_CHAN-1:0] chanCfg,
  input wire logic [NUM_CHAN-1:0] delatch,
  input wire logic [NUM_CHAN-1:0] faultRegRead,
  // per-channel sensors and comparators
  input wire fpl_chan_sense_s [NUM_CHAN-1:0] chanSense,
  // supply monitor and global configuration
  input wire logic ovAbove,
  input wire logic ovBelowHyst,
  input wire logic overvoltage_disable,
  input wire logic statusRegRead,
  // outputs
  output logic [NUM_CHAN-1:0] chanOn,
  output fpl_chan_flags_s [NUM_CHAN-1:0] chanFlags,
  output logic overvoltage_flag,
  output logic fault_out_n,
  output logic [NUM_CHAN-1:0] senseBlank,
  output logic syncOut
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [DUR_W-1:0] fpl_width(input logic isMotor, input logic isSecond,
                                                 input logic longSel);
    if (isMotor)
    begin
      return longSel ? MOTOR_LONG_CYC : MOTOR_SHORT_CYC;
    end
    if (isSecond)
    begin
      return longSel ? WIN_MID_CYC : WIN_SHORT_CYC;
    end
    return longSel ? WIN_LONG_CYC : WIN_SHORT_CYC;
  endfunction : fpl_width

  function automatic logic fpl_win_active(input fpl_win_e st);
    return (st == FPL_WIN_FIRST) || (st == FPL_WIN_SECOND);
  endfunction : fpl_win_active

  // ****************************************
  // shared state
  // ****************************************
  logic [NUM_CHAN-1:0] chanOn_reg, chanOnNext, turnOn, otHold_reg, otFlag_reg, ocFlag_reg, scFlag_reg;
  logic [NUM_CHAN-1:0] winActive, senseBlank_reg, hot;
  logic ovOff_reg, ovFlag_reg, faultN_reg, syncOut_reg, anyHot, anyTurnOn, ovTrip;

  assign anyHot = |hot;
  assign anyTurnOn = |turnOn;
  // enabled overvoltage blocks turn-on in the cycle it is seen, so both channels drop together
  assign ovTrip = ovAbove && !overvoltage_disable;

  // ****************************************
  // per-channel protection
  // ****************************************
  for (genvar g = 0; g < NUM_CHAN; g++)
  begin : g_chan
    fpl_win_e win_reg;
    logic [DUR_W-1:0] durCnt_reg, retryTmr_reg, onAge_reg, width;
    logic [3:0] retryCnt_reg;
    logic retryWait_reg, tripLocked_reg, otOff_reg, armedOnce_reg, cleanOn_reg;
    logic isMotor, ocTrip, scTrip, trip, retryDone, turnOff, flagClr;

    assign isMotor = (chanCfg[g].load_type_select == LOAD_MOTOR);
    assign width = fpl_width(isMotor, win_reg == FPL_WIN_SECOND,
                             (win_reg == FPL_WIN_SECOND) ? chanCfg[g].secondWinLong
                                                         : chanCfg[g].firstWinLong);

    always_comb
    begin
      ocTrip = 1'b0;
      if (chanOn_reg[g])
      begin
        if (isMotor)
        begin
          // high level always caps; staying above the low level too long trips
          ocTrip = chanSense[g].ocHigh || (chanSense[g].ocLow && durCnt_reg >= width);
        end
        else
        begin
          case (win_reg)
            FPL_WIN_FIRST: ocTrip = chanSense[g].ocHigh;
            FPL_WIN_SECOND: ocTrip = chanSense[g].ocMid;
            FPL_WIN_STEADY: ocTrip = chanSense[g].ocLow;
            default: ocTrip = chanSense[g].ocLow;
          endcase
        end
      end
    end

    // only the first moments after turn-on count as a severe short
    assign scTrip = chanOn_reg[g] && chanSense[g].shortSense && (onAge_reg < SC_CHECK_CYC);
    assign trip = ocTrip | scTrip;
    assign hot[g] = chanSense[g].overTemp;
    assign flagClr = faultRegRead[g] && !tripLocked_reg && !retryWait_reg;
    assign retryDone = retryWait_reg && (retryTmr_reg <= DUR_ONE);
    // a trip or any blocking fault forces the switch off in the next cycle
    assign chanOnNext[g] = chanCfg[g].onRequest && !trip && !chanSense[g].overTemp && !otOff_reg
                           && !tripLocked_reg && !retryWait_reg && !ovOff_reg && !ovTrip;
    assign turnOn[g] = chanOnNext[g] && !chanOn_reg[g];
    assign turnOff = chanOn_reg[g] && !chanOnNext[g];
    assign winActive[g] = isMotor ? (win_reg == FPL_WIN_FIRST) : fpl_win_active(win_reg);

    // switch state
    always_ff @(posedge clk_sys or negedge resetn)
    begin
      if (!resetn)
      begin
        chanOn_reg[g] <= 1'b0;
        onAge_reg <= DUR_ZERO;
      end
      else if (clkEn)
      begin
        chanOn_reg[g] <= chanOnNext[g];
        if (turnOn[g])
        begin
          onAge_reg <= DUR_ZERO;
        end
        else if (chanOn_reg[g] && onAge_reg < SC_CHECK_CYC)
        begin
          onAge_reg <= onAge_reg + DUR_ONE;
        end
      end
    end

    // overtemperature latch, hold and flag
    always_ff @(posedge clk_sys or negedge resetn)
    begin
      if (!resetn)
      begin
        otOff_reg <= 1'b0;
        otHold_reg[g] <= 1'b0;
        otFlag_reg[g] <= 1'b0;
      end
      else if (clkEn)
      begin
        if (chanSense[g].overTemp)
        begin
          otOff_reg <= 1'b1;
        end
        else if (chanCfg[g].autoRetryEn || delatch[g])
        begin
          otOff_reg <= 1'b0;
        end
        // hot in on or off state pulls the pin; release needs both cool and a turn-on
        if (chanSense[g].overTemp)
        begin
          otHold_reg[g] <= 1'b1;
        end
        else if (!anyHot && anyTurnOn)
        begin
          otHold_reg[g] <= 1'b0;
        end
        otFlag_reg[g] <= chanSense[g].overTemp || (otFlag_reg[g] && !(faultRegRead[g] && faultN_reg));
      end
    end

    // overcurrent and short-circuit flags, retry and latch
    always_ff @(posedge clk_sys or negedge resetn)
    begin
      if (!resetn)
      begin
        ocFlag_reg[g] <= 1'b0;
        scFlag_reg[g] <= 1'b0;
        retryWait_reg <= 1'b0;
        retryTmr_reg <= DUR_ZERO;
        retryCnt_reg <= 4'h0;
        tripLocked_reg <= 1'b0;
      end
      else if (clkEn)
      begin
        // a new trip beats a read in the same cycle
        ocFlag_reg[g] <= ocTrip || (ocFlag_reg[g] && !flagClr);
        scFlag_reg[g] <= scTrip || (scFlag_reg[g] && !flagClr);
        if (delatch[g])
        begin
          tripLocked_reg <= 1'b0;
          retryWait_reg <= 1'b0;
          retryCnt_reg <= 4'h0;
          retryTmr_reg <= DUR_ZERO;
        end
        else if (trip)
        begin
          if (chanCfg[g].autoRetryEn && retryCnt_reg < RETRY_MAX)
          begin
            retryWait_reg <= 1'b1;
            retryTmr_reg <= RETRY_DELAY_CYC;
            retryCnt_reg <= retryCnt_reg + 4'h1;
          end
          else
          begin
            tripLocked_reg <= 1'b1;
          end
        end
        else if (retryWait_reg)
        begin
          retryTmr_reg <= retryTmr_reg - DUR_ONE;
          if (retryDone)
          begin
            retryWait_reg <= 1'b0;
          end
        end
      end
    end

    // profile windows and duration counter
    always_ff @(posedge clk_sys or negedge resetn)
    begin
      if (!resetn)
      begin
        win_reg <= FPL_WIN_IDLE;
        durCnt_reg <= DUR_ZERO;
        armedOnce_reg <= 1'b0;
        cleanOn_reg <= 1'b0;
      end
      else if (clkEn)
      begin
        if (delatch[g])
        begin
          win_reg <= FPL_WIN_IDLE;
          durCnt_reg <= DUR_ZERO;
          armedOnce_reg <= 1'b0;
          cleanOn_reg <= 1'b0;
        end
        else if (isMotor)
        begin
          if (turnOn[g])
          begin
            cleanOn_reg <= 1'b1;
          end
          else if (chanOn_reg[g] && chanSense[g].ocLow)
          begin
            cleanOn_reg <= 1'b0;
          end
          win_reg <= (chanOn_reg[g] && chanSense[g].ocLow) ? FPL_WIN_FIRST : FPL_WIN_IDLE;
          if (turnOff && cleanOn_reg && !chanSense[g].ocLow && !chanCfg[g].switchMode)
          begin
            durCnt_reg <= DUR_ZERO;
          end
          else if (chanOn_reg[g] && chanSense[g].ocLow && durCnt_reg != 16'hffff)
          begin
            // off-times leave the count untouched, so pulses accumulate
            durCnt_reg <= durCnt_reg + DUR_ONE;
          end
        end
        else
        begin
          if (turnOn[g] && (!chanCfg[g].switchMode || !armedOnce_reg))
          begin
            win_reg <= FPL_WIN_FIRST;
            durCnt_reg <= DUR_ZERO;
            armedOnce_reg <= 1'b1;
          end
          else if (retryDone)
          begin
            durCnt_reg <= DUR_ZERO;
          end
          else if (chanOn_reg[g] && fpl_win_active(win_reg))
          begin
            if (durCnt_reg >= width)
            begin
              win_reg <= (win_reg == FPL_WIN_FIRST) ? FPL_WIN_SECOND : FPL_WIN_STEADY;
              durCnt_reg <= DUR_ZERO;
            end
            else
            begin
              durCnt_reg <= durCnt_reg + DUR_ONE;
            end
          end
        end
      end
    end

    assign chanFlags[g].overtemp_flag = otFlag_reg[g];
    assign chanFlags[g].overcurrent_flag = ocFlag_reg[g];
    assign chanFlags[g].short_circuit_flag = scFlag_reg[g];
  end

  // ****************************************
  // supply overvoltage
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ovOff_reg <= 1'b0;
      ovFlag_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      if (ovTrip)
      begin
        ovOff_reg <= 1'b1;
      end
      else if (ovBelowHyst || overvoltage_disable)
      begin
        ovOff_reg <= 1'b0;
      end
      // warning still set when protection is disabled
      ovFlag_reg <= ovAbove || (ovFlag_reg && !(statusRegRead && !ovOff_reg));
    end
  end

  // ****************************************
  // fault pin, blanking and sync
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      faultN_reg <= FAULT_N_RST;
      senseBlank_reg <= '0;
      syncOut_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      faultN_reg <= !(|otHold_reg || |ocFlag_reg || |scFlag_reg || ovOff_reg);
      senseBlank_reg <= winActive;
      syncOut_reg <= |winActive;
    end
  end

  assign chanOn = chanOn_reg;
  assign overvoltage_flag = ovFlag_reg;
  assign fault_out_n = faultN_reg;
  assign senseBlank = senseBlank_reg;
  assign syncOut = syncOut_reg;

endmodule : fpl_fault_protection

// ### hdl/fpl_pkg.sv
// shared constants, states and carriers of the two-channel fault protection block
// assumes the 125 MHz system clock; all times below are turned into cycle counts here
package fpl_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  // window widths are limits, so they round down
  localparam int WIN_SHORT_NS = 2000;
  localparam int WIN_LONG_NS = 8000;
  localparam int WIN_MID_NS = 4000;
  localparam int MOTOR_SHORT_NS = 4000;
  localparam int MOTOR_LONG_NS = 16000;
  // least times, rounded up
  localparam int RETRY_DELAY_NS = 16000;
  // short-circuit check after turn-on is a longest time, rounded down
  localparam int SC_CHECK_NS = 200;

  localparam int DUR_W = 16;
  localparam logic [DUR_W-1:0] WIN_SHORT_CYC = DUR_W'(WIN_SHORT_NS / CLK_PERIOD_NS);
  localparam logic [DUR_W-1:0] WIN_LONG_CYC = DUR_W'(WIN_LONG_NS / CLK_PERIOD_NS);
  localparam logic [DUR_W-1:0] WIN_MID_CYC = DUR_W'(WIN_MID_NS / CLK_PERIOD_NS);
  localparam logic [DUR_W-1:0] MOTOR_SHORT_CYC = DUR_W'(MOTOR_SHORT_NS / CLK_PERIOD_NS);
  localparam logic [DUR_W-1:0] MOTOR_LONG_CYC = DUR_W'(MOTOR_LONG_NS / CLK_PERIOD_NS);
  localparam logic [DUR_W-1:0] RETRY_DELAY_CYC =
    DUR_W'((RETRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DUR_W-1:0] SC_CHECK_CYC = DUR_W'(SC_CHECK_NS / CLK_PERIOD_NS);

  // ****************************************
  // encodings and reset values
  // ****************************************
  localparam logic LOAD_LIGHTING = 1'h0;
  localparam logic LOAD_MOTOR = 1'h1;
  localparam logic FAULT_N_RST = 1'h1;
  localparam logic [DUR_W-1:0] DUR_ZERO = 16'h0000;
  localparam logic [DUR_W-1:0] DUR_ONE = 16'h0001;

  typedef enum logic [1:0] {
    FPL_WIN_IDLE = 2'b00,
    FPL_WIN_FIRST = 2'b01,
    FPL_WIN_SECOND = 2'b10,
    FPL_WIN_STEADY = 2'b11
  } fpl_win_e;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic onRequest;
    logic switchMode;
    logic autoRetryEn;
    logic load_type_select;
    logic firstWinLong;
    logic secondWinLong;
  } fpl_chan_cfg_s;

  typedef struct packed {
    logic overTemp;
    logic ocHigh;
    logic ocMid;
    logic ocLow;
    logic shortSense;
  } fpl_chan_sense_s;

  typedef struct packed {
    logic overtemp_flag;
    logic overcurrent_flag;
    logic short_circuit_flag;
  } fpl_chan_flags_s;

endpackage : fpl_pkg

// ### testbench/fpl_fault_protection_properties.sv
// assertions on the ports of the fault protection block
// assumes clkEn is held high, so every rising edge advances state
`timescale 1ns/1ns
module fpl_fault_protection_properties
  import fpl_pkg::*;
#(
  parameter int NUM_CHAN = 2,
  parameter logic [3:0] RETRY_MAX = 4'hf
)
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  // control and sensing
  input wire fpl_chan_cfg_s [NUM_CHAN-1:0] chanCfg,
  input wire logic [NUM_CHAN-1:0] delatch,
  input wire logic [NUM_CHAN-1:0] faultRegRead,
  input wire fpl_chan_sense_s [NUM_CHAN-1:0] chanSense,
  input wire logic ovAbove,
  input wire logic ovBelowHyst,
  input wire logic overvoltage_disable,
  input wire logic statusRegRead,
  // outputs
  input wire logic [NUM_CHAN-1:0] chanOn,
  input wire fpl_chan_flags_s [NUM_CHAN-1:0] chanFlags,
  input wire logic overvoltage_flag,
  input wire logic fault_out_n,
  input wire logic [NUM_CHAN-1:0] senseBlank,
  input wire logic syncOut
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // ****
  // per channel
  // ****
  for (genvar i = 0; i < NUM_CHAN; i++)
  begin : g_ch
    AST_OT_TRIP: assert property (chanOn[i] && chanSense[i].overTemp |=> !chanOn[i] && chanFlags[i].overtemp_flag)
      else $error("overtemperature left the channel on");
    AST_OT_PIN: assert property ($rose(chanFlags[i].overtemp_flag) |=> !fault_out_n)
      else $error("fault pin stayed high after overtemperature");
    AST_OT_CLR: assert property ($fell(chanFlags[i].overtemp_flag) |-> $past(faultRegRead[i]) && $past(fault_out_n))
      else $error("overtemperature flag cleared without a read");
    AST_OC_TRIP: assert property (chanOn[i] && chanSense[i].ocHigh |=> !chanOn[i] && chanFlags[i].overcurrent_flag)
      else $error("high current left the channel on");
    AST_OC_PIN: assert property (chanFlags[i].overcurrent_flag |=> !fault_out_n)
      else $error("fault pin high with overcurrent flag set");
    AST_SC_TRIP: assert property ($rose(chanOn[i]) ##1 (chanOn[i] && chanSense[i].shortSense)
      |=> !chanOn[i] && chanFlags[i].short_circuit_flag)
      else $error("short at turn-on left the channel on");
    AST_SYNC: assert property ($rose(chanOn[i]) && !chanCfg[i].switchMode
      && chanCfg[i].load_type_select == LOAD_LIGHTING |=> senseBlank[i] && syncOut)
      else $error("lighting turn-on left sensing unblanked");
  end

  // ****
  // shared supply and pin
  // ****
  AST_OV_OFF: assert property (ovAbove && !overvoltage_disable |=> chanOn == '0 && overvoltage_flag)
    else $error("overvoltage left a channel on");
  AST_OV_WARN: assert property (ovAbove && overvoltage_disable |=> overvoltage_flag)
    else $error("disabled overvoltage did not raise its warning");
  AST_OV_CLR: assert property ($fell(overvoltage_flag) |-> $past(statusRegRead))
    else $error("overvoltage flag cleared without a status read");
  AST_RELEASE: assert property ($rose(fault_out_n) |-> !chanSense[0].overTemp && !chanSense[1].overTemp)
    else $error("fault pin released while a channel is hot");

  COV_FAULT: cover property ($fell(fault_out_n));
  COV_OV: cover property (ovAbove && !overvoltage_disable && chanOn != '0);
  COV_SYNC: cover property ($rose(syncOut));
endmodule : fpl_fault_protection_properties

bind fpl_fault_protection fpl_fault_protection_properties #(.NUM_CHAN(NUM_CHAN), .RETRY_MAX(RETRY_MAX)) u_props (
  .clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn), .chanCfg(chanCfg), .delatch(delatch),
  .faultRegRead(faultRegRead), .chanSense(chanSense), .ovAbove(ovAbove), .ovBelowHyst(ovBelowHyst),
  .overvoltage_disable(overvoltage_disable), .statusRegRead(statusRegRead), .chanOn(chanOn),
  .chanFlags(chanFlags), .overvoltage_flag(overvoltage_flag), .fault_out_n(fault_out_n),
  .senseBlank(senseBlank), .syncOut(syncOut));

// ### testbench/fpl_fault_protection_tb_top.sv
// self-checking bench for the fault protection block with a host read model
// assumes one 125 MHz clock; clkEn is held high throughout
`timescale 1ns/1ns
module fpl_fault_protection_tb_top
  import fpl_pkg::*;
;
  typedef struct packed {logic [12:0] mask; logic [12:0] val;} fpl_note_s;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  fpl_chan_cfg_s [1:0] chanCfg = '0;
  fpl_chan_sense_s [1:0] chanSense = '0;
  logic [1:0] delatch = 2'h0;
  logic [2:0] readReq = 3'h0;
  logic ovAbove = 1'b0, ovBelowHyst = 1'b1, ovDis = 1'b0, slowHost = 1'b0;
  logic [1:0] faultRegRead, chanOn, senseBlank;
  logic statusRegRead, ovFlag, faultN, syncOut;
  fpl_chan_flags_s [1:0] chanFlags;
  fpl_note_s noteQ[$];
  fpl_note_s curNote;
  int badCount = 0;
  int checked = 0;
  int c, bOn, bBl, bOt, bOc, bSc;
  wire logic [12:0] obs = {faultN, ovFlag, syncOut, senseBlank, chanOn, chanFlags};

  always #4 clk_sys = ~clk_sys;

  fpl_fault_protection #(.NUM_CHAN(2)) dut (.clk_sys(clk_sys), .resetn(resetn), .clkEn(1'b1),
    .chanCfg(chanCfg), .delatch(delatch), .faultRegRead(faultRegRead), .chanSense(chanSense),
    .ovAbove(ovAbove), .ovBelowHyst(ovBelowHyst), .overvoltage_disable(ovDis),
    .statusRegRead(statusRegRead), .chanOn(chanOn), .chanFlags(chanFlags), .overvoltage_flag(ovFlag),
    .fault_out_n(faultN), .senseBlank(senseBlank), .syncOut(syncOut));

  fpl_host_model host (.clk_sys(clk_sys), .resetn(resetn), .readReq(readReq), .slowAnswer(slowHost),
    .faultRegRead(faultRegRead), .statusRegRead(statusRegRead));

  // ****
  // tasks
  // ****
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic chk(input int b, input logic v);
    noteQ.push_back('{13'h0001 << b, {12'h000, v} << b});
  endtask : chk

  task automatic rd(input int r);
    slowHost = 1'($urandom_range(1, 0));
    readReq[r] = 1'b1;
    step(1);
    readReq[r] = 1'b0;
    step(2);
  endtask : rd

  task automatic clearCh();
    delatch[c] = 1'b1;
    step(1);
    delatch[c] = 1'b0;
    rd(c);
  endtask : clearCh

  task automatic reOn();
    chanCfg[c].onRequest = 1'b0;
    step(2);
    chanCfg[c].onRequest = 1'b1;
    step(2);
  endtask : reOn

  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : completeRun

  // notes are compared at the falling edge, when outputs have settled
  always @(negedge clk_sys)
    while (noteQ.size() > 0)
    begin
      curNote = noteQ.pop_front();
      checked++;
      if ((obs & curNote.mask) !== curNote.val)
      begin
        badCount++;
        $display("mismatch at %0t: outputs %h expected %h mask %h", $time, obs, curNote.val, curNote.mask);
      end
    end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    badCount++;
    completeRun();
  end

  // ****
  // scenarios
  // ****
  initial
  begin
    void'($urandom(19334));
    c = int'($urandom_range(1, 0));
    bOn = 6 + c;
    bBl = 8 + c;
    bOt = 3 * c + 2;
    bOc = 3 * c + 1;
    bSc = 3 * c;
    step(5);
    resetn = 1'b1;
    step(1);
    noteQ.push_back('{13'h1fff, 13'h1000});
    // overtemperature while on, recovered by auto-retry
    chanCfg[c].autoRetryEn = 1'b1;
    chanCfg[c].onRequest = 1'b1;
    step(3);
    chk(10, 1'b1);
    chk(bBl, 1'b1);
    chanSense[c].overTemp = 1'b1;
    step(1);
    chk(bOn, 1'b0);
    chk(bOt, 1'b1);
    step(1);
    chk(12, 1'b0);
    rd(c);
    chk(bOt, 1'b1);
    chanSense[c].overTemp = 1'b0;
    step(4);
    chk(bOn, 1'b1);
    chk(12, 1'b1);
    rd(c);
    chk(bOt, 1'b0);
    // overtemperature while off
    chanCfg[c].onRequest = 1'b0;
    step(2);
    chanSense[c].overTemp = 1'b1;
    step(3);
    chk(12, 1'b0);
    chanSense[c].overTemp = 1'b0;
    step(4);
    chk(12, 1'b0);
    chanCfg[c].onRequest = 1'b1;
    step(4);
    chk(12, 1'b1);
    rd(c);
    // lighting profile: middle current tolerated early, low limit later
    chanCfg[c].autoRetryEn = 1'b0;
    chanSense[c].ocMid = 1'b1;
    chanSense[c].ocLow = 1'b1;
    step(10);
    chk(bOn, 1'b1);
    chanSense[c] = '0;
    step(2 * int'(WIN_SHORT_CYC) + 20);
    chk(10, 1'b0);
    chk(bBl, 1'b0);
    chanSense[c].ocLow = 1'b1;
    step(1);
    chk(bOn, 1'b0);
    chk(bOc, 1'b1);
    step(1);
    chk(12, 1'b0);
    chanSense[c] = '0;
    rd(c);
    chk(bOc, 1'b1);
    clearCh();
    chk(bOc, 1'b0);
    chk(12, 1'b1);
    // high current in the first window, recovered by one auto-retry
    chanCfg[c].autoRetryEn = 1'b1;
    chanSense[c].ocHigh = 1'b1;
    step(1);
    chk(bOn, 1'b0);
    chk(bOc, 1'b1);
    chanSense[c] = '0;
    step(int'(RETRY_DELAY_CYC) - 2);
    chk(bOn, 1'b0);
    step(4);
    chk(bOn, 1'b1);
    chk(10, 1'b1);
    rd(c);
    chk(bOc, 1'b0);
    chk(12, 1'b1);
    chanCfg[c].autoRetryEn = 1'b0;
    // motor profile: window opened by current, limited by its width
    chanCfg[c].load_type_select = LOAD_MOTOR;
    reOn();
    chk(10, 1'b0);
    chanSense[c].ocLow = 1'b1;
    step(3);
    chk(10, 1'b1);
    step(int'(MOTOR_SHORT_CYC) - 10);
    chk(bOn, 1'b1);
    step(15);
    chk(bOn, 1'b0);
    chk(bOc, 1'b1);
    chanSense[c] = '0;
    clearCh();
    // short circuit just after turn-on
    reOn();
    chanSense[c].shortSense = 1'b1;
    step(1);
    chk(bOn, 1'b0);
    chk(bSc, 1'b1);
    step(1);
    chk(12, 1'b0);
    chanSense[c] = '0;
    clearCh();
    // supply overvoltage, enabled then disabled
    chanCfg[1-c].onRequest = 1'b1;
    step(3);
    ovAbove = 1'b1;
    ovBelowHyst = 1'b0;
    step(1);
    chk(6, 1'b0);
    chk(7, 1'b0);
    chk(11, 1'b1);
    step(1);
    chk(12, 1'b0);
    ovAbove = 1'b0;
    rd(2);
    chk(7, 1'b0);
    chk(11, 1'b1);
    ovBelowHyst = 1'b1;
    step(4);
    chk(bOn, 1'b1);
    chk(12, 1'b1);
    rd(2);
    chk(11, 1'b0);
    ovDis = 1'b1;
    ovAbove = 1'b1;
    ovBelowHyst = 1'b0;
    step(3);
    chk(11, 1'b1);
    chk(6, 1'b1);
    chk(7, 1'b1);
    chk(12, 1'b1);
    step(1);
    completeRun();
  end
endmodule : fpl_fault_protection_tb_top

// ### testbench/fpl_host_model.sv
// host side model: turns read requests into one-cycle register read strobes
// assumes requests change just after a rising edge and are held one cycle or more
`timescale 1ns/1ns
module fpl_host_model
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // requests, bit 2 reads the status register
  input wire logic [2:0] readReq,
  input wire logic slowAnswer,
  // read strobes toward the block
  output logic [1:0] faultRegRead,
  output logic statusRegRead
);
  logic [2:0] prevReq;
  logic [2:0] lateRead;
  logic [2:0] newRead;
  assign newRead = readReq & ~prevReq;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      prevReq <= 3'h0;
      lateRead <= 3'h0;
    end
    else
    begin
      prevReq <= readReq;
      lateRead <= newRead;
    end
  // a slow host ends its frame a cycle later; the strobe stays one cycle long
  assign {statusRegRead, faultRegRead} = slowAnswer ? lateRead : newRead;
endmodule : fpl_host_model
